// [verilog/debug_pc_tracking_priority.sv]
// Debug entry priority, PC advance tracking and test port of the core
`timescale 1ns/10ps
`default_nettype none
module debug_pc_tracking_priority
  import dbg_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Test port pins from the debugger
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Debug request pin
  input wire logic debug_request_input_in,
  // Core events, same clock
  input wire logic bkpt_hit_in,
  input wire logic wpt_hit_in,
  input wire logic prefetch_abort_in,
  input wire logic data_abort_in,
  input wire logic irq_pending_in,
  input wire logic other_exc_in,
  input wire logic [4:0] exc_mode_in,
  input wire logic vector_fetched_in,
  input wire logic insn_exec_in,
  input wire logic break_point_flag_in,
  input wire logic sys_done_in,
  input wire logic sys_abort_in,
  // Cells sampled into the boundary chain
  input wire logic [DATA_W-1:0] core_data_in,
  input wire logic [DATA_W-1:0] core_addr_in,
  input wire logic [CTRL_CELLS-1:0] ctrl_cells_in,
  // Core status outputs
  output logic debug_acknowledge_out,
  output logic irq_disable_out,
  output logic sys_speed_out,
  output logic resume_fetch_out,
  output logic [4:0] mode_out,
  output logic [31:0] pc_adv_out,
  output logic [CHAIN_LEN-1:0] chain_drive_out
);
  // Test controller states
  typedef enum logic [15:0] {
    T_RESET = 16'h0001, T_IDLE = 16'h0002, T_SELDR = 16'h0004,
    T_CAPDR = 16'h0008, T_SHDR = 16'h0010, T_EX1DR = 16'h0020,
    T_PSDR = 16'h0040, T_EX2DR = 16'h0080, T_UPDR = 16'h0100,
    T_SELIR = 16'h0200, T_CAPIR = 16'h0400, T_SHIR = 16'h0800,
    T_EX1IR = 16'h1000, T_PSIR = 16'h2000, T_EX2IR = 16'h4000,
    T_UPIR = 16'h8000
  } tap_t;

  // Core debug states
  typedef enum logic [3:0] {
    D_RUN = 4'h1,   // Normal execution
    D_HOLD = 4'h2,  // Entry waiting for abort vector fetch
    D_DEBUG = 4'h4, // Halted, instructions clocked by debugger
    D_SYS = 4'h8    // System-speed access in flight
  } dbg_t;

  typedef struct packed {
    logic [2:0] tck_s;   // Clock pin synchroniser and edge history
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] dreq_s;
    tap_t tap;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic tdo;
    logic tdo_oe;
    dbg_t st;
    logic [31:0] pc_adv;
    logic [4:0] mode;
    logic [1:0] rsn;
    logic irq_rem;
    logic abt_rem;
    logic [1:0] insn_cnt;
    logic sys_next;
    logic en;
    logic resume;
    logic [31:0] prdata;
    logic err;
  } state_t;

  state_t q, d;

  // Next test controller state for one clock rise
  function automatic tap_t tap_next(input tap_t s, input logic m);
    case (s)
      T_RESET: tap_next = m ? T_RESET : T_IDLE;
      T_IDLE: tap_next = m ? T_SELDR : T_IDLE;
      T_SELDR: tap_next = m ? T_SELIR : T_CAPDR;
      T_CAPDR: tap_next = m ? T_EX1DR : T_SHDR;
      T_SHDR: tap_next = m ? T_EX1DR : T_SHDR;
      T_EX1DR: tap_next = m ? T_UPDR : T_PSDR;
      T_PSDR: tap_next = m ? T_EX2DR : T_PSDR;
      T_EX2DR: tap_next = m ? T_UPDR : T_SHDR;
      T_UPDR: tap_next = m ? T_SELDR : T_IDLE;
      T_SELIR: tap_next = m ? T_RESET : T_CAPIR;
      T_CAPIR: tap_next = m ? T_EX1IR : T_SHIR;
      T_SHIR: tap_next = m ? T_EX1IR : T_SHIR;
      T_EX1IR: tap_next = m ? T_UPIR : T_PSIR;
      T_PSIR: tap_next = m ? T_EX2IR : T_PSIR;
      T_EX2IR: tap_next = m ? T_UPIR : T_SHIR;
      T_UPIR: tap_next = m ? T_SELDR : T_IDLE;
      default: tap_next = T_RESET;
    endcase
  endfunction : tap_next

  // Boundary chain selected by the current instruction
  function automatic logic chain_sel(input logic [IR_W-1:0] i);
    chain_sel = (i == IR_EXTEST) || (i == IR_INTEST);
  endfunction : chain_sel

  logic tck_rise;
  logic tck_fall;
  logic dreq;
  logic ch_sout;
  logic [CHAIN_LEN-1:0] ch_par;
  logic [CTRL_CELLS-1:0] ctrl_v;
  logic acc;
  logic wr;

  // Edges taken from the second and third stages only
  assign tck_rise = q.tck_s[1] & ~q.tck_s[2];
  assign tck_fall = ~q.tck_s[1] & q.tck_s[2];
  assign dreq = q.dreq_s[1];
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;

  // Control cells with the core's own debug signals in their slots
  always_comb begin
    ctrl_v = ctrl_cells_in;
    ctrl_v[IDX_BKPT-IDX_BKPT] = bkpt_hit_in;
    ctrl_v[IDX_DACK-IDX_BKPT] = debug_acknowledge_out;
    ctrl_v[IDX_DREQ-IDX_BKPT] = dreq;
  end

  // Data cells first, then control cells
  assign ch_par[IDX_DATA0 +: DATA_W] = core_data_in;
  assign ch_par[IDX_BKPT +: CTRL_CELLS] = ctrl_v;

  // Address cells run from bit 31 down to bit 0
  for (genvar k = 0; k < DATA_W; k++) begin : g_addr
    assign ch_par[IDX_ADDR31+k] = core_addr_in[DATA_W-1-k];
  end

  boundary_chain #(
    .LEN(CHAIN_LEN)
  ) u_chain (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .capture_in(tck_rise && q.tap == T_CAPDR && chain_sel(q.ir)),
    .shift_in(tck_rise && q.tap == T_SHDR && chain_sel(q.ir)),
    .update_in(tck_rise && q.tap == T_UPDR && chain_sel(q.ir)),
    .serial_in(q.tdi_s[1]),
    .par_in(ch_par),
    .serial_out(ch_sout),
    .par_out(chain_drive_out)
  );

  // All next-state logic: sync, test port, debug tracking, APB
  always_comb begin
    d = q;
    d.tck_s = {q.tck_s[1:0], tck_in};
    d.tms_s = {q.tms_s[0], tms_in};
    d.tdi_s = {q.tdi_s[0], tdi_in};
    d.dreq_s = {q.dreq_s[0], debug_request_input_in};
    d.resume = 1'b0;

    // Test port advances on each sampled clock rise
    if (tck_rise) begin
      d.tap = tap_next(q.tap, q.tms_s[1]);
      case (q.tap)
        T_RESET: begin
          d.ir = IR_BYPASS;
        end
        T_CAPIR: begin
          d.ir_sh = IR_CAPTURE;
        end
        T_SHIR: begin
          d.ir_sh = {q.tdi_s[1], q.ir_sh[IR_W-1:1]};
        end
        T_UPIR: begin
          d.ir = q.ir_sh;
        end
        T_CAPDR: begin
          d.byp = 1'b0;
        end
        T_SHDR: begin
          d.byp = q.tdi_s[1];
        end
        default: begin
        end
      endcase
    end

    // Output driven on the falling edge, only while shifting
    if (tck_fall) begin
      d.tdo_oe = (q.tap == T_SHDR) || (q.tap == T_SHIR);
      if (q.tap == T_SHIR) begin
        d.tdo = q.ir_sh[0];
      end else if (chain_sel(q.ir)) begin
        d.tdo = ch_sout;
      end else begin
        d.tdo = q.byp;
      end
    end

    // Writes come first, so a flag set further down wins over a clear
    if (wr && paddr_in == REG_CTRL) begin
      d.en = pwdata_in[CTRL_EN_BIT];
      if (pwdata_in[CTRL_CLR_BIT]) begin
        d.irq_rem = 1'b0;
        d.abt_rem = 1'b0;
      end
    end

    // Debug state tracking
    case (q.st)
      D_RUN: begin
        if (!q.en) begin
          d.st = D_RUN;
        end else if (bkpt_hit_in && !prefetch_abort_in) begin
          // Pending interrupts play no part here
          d.st = D_DEBUG;
          d.pc_adv = ADV_BKPT;
          d.rsn = RSN_BKPT;
          d.insn_cnt = '0;
        end else if (wpt_hit_in && data_abort_in) begin
          // Wait for abort mode and the vector fetch first
          d.st = D_HOLD;
          d.mode = MODE_ABT;
          d.abt_rem = 1'b1;
          d.rsn = RSN_WEXC;
        end else if (wpt_hit_in && irq_pending_in) begin
          d.st = D_DEBUG;
          d.mode = MODE_IRQ;
          d.irq_rem = 1'b1;
          d.pc_adv = ADV_WEXC;
          d.rsn = RSN_WEXC;
          d.insn_cnt = '0;
        end else if (wpt_hit_in && other_exc_in) begin
          d.st = D_DEBUG;
          d.mode = exc_mode_in;
          d.pc_adv = ADV_WEXC;
          d.rsn = RSN_WEXC;
          d.insn_cnt = '0;
        end else if (wpt_hit_in) begin
          // Triggering access already done, return skips it
          d.st = D_DEBUG;
          d.pc_adv = ADV_WPT;
          d.rsn = RSN_WPT;
          d.insn_cnt = '0;
        end else if (dreq) begin
          // Last instruction has completed before entry
          d.st = D_DEBUG;
          d.pc_adv = ADV_DREQ;
          d.rsn = RSN_DREQ;
          d.insn_cnt = '0;
          if (irq_pending_in) begin
            d.mode = MODE_IRQ;
            d.irq_rem = 1'b1;
          end
        end
      end
      D_HOLD: begin
        if (vector_fetched_in) begin
          d.st = D_DEBUG;
          d.pc_adv = ADV_WEXC;
          d.insn_cnt = '0;
        end
      end
      D_DEBUG: begin
        if (q.ir == IR_RESTART && q.tap == T_IDLE) begin
          // Resume only once the controller sits in run-test/idle
          d.st = D_RUN;
          d.resume = 1'b1;
          d.sys_next = 1'b0;
        end else if (insn_exec_in) begin
          d.sys_next = break_point_flag_in;
          if (q.insn_cnt != MIN_INSNS) begin
            d.insn_cnt = q.insn_cnt + 2'h1;
          end
          if (q.sys_next) begin
            d.st = D_SYS;
            d.pc_adv = q.pc_adv + ADV_SYS;
          end else begin
            d.pc_adv = q.pc_adv + ADV_INSN;
          end
        end
      end
      D_SYS: begin
        if (sys_abort_in) begin
          d.mode = MODE_ABT;
          d.abt_rem = 1'b1;
          d.st = D_DEBUG;
        end else if (sys_done_in) begin
          d.st = D_DEBUG;
        end
      end
      default: begin
        d.st = D_RUN;
      end
    endcase

    // APB read data prepared in the setup cycle, answered next
    d.prdata = '0;
    d.err = 1'b0;
    if (psel_in && !penable_in) begin
      case (paddr_in)
        REG_CTRL: begin
          d.prdata[CTRL_EN_BIT] = q.en;
        end
        REG_STAT: begin
          d.prdata[STAT_ACK_BIT] = q.st == D_DEBUG;
          d.prdata[STAT_SYS_BIT] = q.st == D_SYS;
          d.prdata[STAT_HOLD_BIT] = q.st == D_HOLD;
          d.prdata[STAT_IRQ_BIT] = q.irq_rem;
          d.prdata[STAT_ABT_BIT] = q.abt_rem;
          d.prdata[STAT_MIN_BIT] = q.insn_cnt == MIN_INSNS;
          d.prdata[STAT_RSN_LSB +: 2] = q.rsn;
          d.prdata[STAT_MODE_LSB +: 5] = q.mode;
        end
        REG_PCADV: begin
          d.prdata = q.pc_adv;
        end
        REG_CHAIN: begin
          d.prdata[IR_W-1:0] = q.ir;
        end
        default: begin
          d.err = 1'b1;
        end
      endcase
    end

  end

  // Single state register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q <= '0;
      q.tap <= T_RESET;
      q.ir <= IR_BYPASS;
      q.st <= D_RUN;
      q.mode <= MODE_USR;
      q.en <= CTRL_EN_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign prdata_out = q.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = acc & q.err;
  assign tdo_out = q.tdo;
  assign tdo_oe_out = q.tdo_oe;
  assign debug_acknowledge_out = q.st == D_DEBUG;
  assign irq_disable_out = q.st != D_RUN;
  assign sys_speed_out = q.st == D_SYS;
  assign resume_fetch_out = q.resume;
  assign mode_out = q.mode;
  assign pc_adv_out = q.pc_adv;
endmodule : debug_pc_tracking_priority
`default_nettype wire

// [verilog/dbg_pkg.sv]
// Constants shared by the debug PC tracker and its boundary chain
package dbg_pkg;
  // APB register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_PCADV = 12'h008;
  localparam logic [11:0] REG_CHAIN = 12'h00C;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  // Status register fields
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_SYS_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_IRQ_BIT = 3;
  localparam int STAT_ABT_BIT = 4;
  localparam int STAT_MIN_BIT = 5;
  localparam int STAT_RSN_LSB = 8;
  localparam int STAT_MODE_LSB = 16;
  // Program counter advance, in word addresses
  localparam logic [31:0] ADV_BKPT = 32'h0000_0004;
  localparam logic [31:0] ADV_WPT = 32'h0000_0004;
  localparam logic [31:0] ADV_WEXC = 32'h0000_0003;
  localparam logic [31:0] ADV_DREQ = 32'h0000_0003;
  localparam logic [31:0] ADV_INSN = 32'h0000_0001;
  localparam logic [31:0] ADV_SYS = 32'h0000_0003;
  localparam logic [1:0] MIN_INSNS = 2'h2;
  // Entry reasons
  localparam logic [1:0] RSN_BKPT = 2'h0;
  localparam logic [1:0] RSN_WPT = 2'h1;
  localparam logic [1:0] RSN_WEXC = 2'h2;
  localparam logic [1:0] RSN_DREQ = 2'h3;
  // Processor mode codes
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_ABT = 5'h17;
  // Boundary chain layout, cell position minus one gives the bit index
  localparam int CHAIN_LEN = 105;
  localparam int DATA_W = 32;
  localparam int IDX_DATA0 = 0;
  localparam int IDX_BKPT = 32;
  localparam int IDX_DACK = 46;
  localparam int IDX_DREQ = 52;
  localparam int IDX_CTRL_LAST = 72;
  localparam int IDX_ADDR31 = 73;
  localparam int CTRL_CELLS = 41;
  // Test instruction codes, four bits wide
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_RESTART = 4'h4;
  localparam logic [3:0] IR_INTEST = 4'hC;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
endpackage : dbg_pkg

// [verilog/boundary_chain.sv]
// Boundary scan chain with capture, shift and update stages
`timescale 1ns/10ps
`default_nettype none
module boundary_chain
  import dbg_pkg::*;
#(
  parameter int LEN = CHAIN_LEN
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Stage strobes, one cycle each
  input wire logic capture_in,
  input wire logic shift_in,
  input wire logic update_in,
  // Serial and parallel data
  input wire logic serial_in,
  input wire logic [LEN-1:0] par_in,
  output logic serial_out,
  output logic [LEN-1:0] par_out
);
  initial begin
    if (LEN < 2) $error("boundary_chain: LEN too small");
  end

  typedef struct packed {
    logic [LEN-1:0] sh;  // Shift stage
    logic [LEN-1:0] upd; // Update latch driving pads or core
  } chain_t;

  chain_t q, d;

  // Capture beats shift; position one sits next to the serial output
  always_comb begin
    d = q;
    if (capture_in) begin
      d.sh = par_in;
    end else if (shift_in) begin
      d.sh = {serial_in, q.sh[LEN-1:1]};
    end
    if (update_in) begin
      d.upd = q.sh;
    end
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign serial_out = q.sh[0];
  assign par_out = q.upd;
endmodule : boundary_chain
`default_nettype wire

// [sim/dbg_checker.sv]
// Port-level assertions for the debug tracker
`timescale 1ns/10ps
`default_nettype none
module dbg_checker
  import dbg_pkg::*;
(
  // Clock, reset and bus
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pslverr_out,
  // Core events
  input wire logic debug_request_input_in,
  input wire logic bkpt_hit_in,
  input wire logic wpt_hit_in,
  input wire logic prefetch_abort_in,
  input wire logic data_abort_in,
  input wire logic irq_pending_in,
  input wire logic other_exc_in,
  input wire logic [4:0] exc_mode_in,
  input wire logic vector_fetched_in,
  input wire logic insn_exec_in,
  input wire logic break_point_flag_in,
  input wire logic sys_abort_in,
  // Status outputs
  input wire logic debug_acknowledge_out,
  input wire logic irq_disable_out,
  input wire logic sys_speed_out,
  input wire logic resume_fetch_out,
  input wire logic [4:0] mode_out,
  input wire logic [31:0] pc_adv_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic en_q; // Shadow of the enable bit
  logic flg_q; // Last debug instruction carried the flag
  logic [2:0] dr_q; // Request pin history, covers the synchroniser
  logic run;
  logic wp;
  // Shadows follow bus writes and executed instructions
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      en_q <= CTRL_EN_RST;
      flg_q <= 1'b0;
      dr_q <= 3'h0;
    end else begin
      dr_q <= {dr_q[1:0], debug_request_input_in};
      if (psel_in && penable_in && pwrite_in && paddr_in == REG_CTRL) begin
        en_q <= pwdata_in[CTRL_EN_BIT];
      end
      if (insn_exec_in && debug_acknowledge_out) begin
        flg_q <= break_point_flag_in;
      end
    end
  end
  // Events count only while running and enabled
  assign run = !irq_disable_out && en_q;
  assign wp = run && wpt_hit_in && !bkpt_hit_in;
  bkpt_entry_a:
  assert property (run && bkpt_hit_in && !prefetch_abort_in |=> debug_acknowledge_out
    && pc_adv_out == ADV_BKPT && mode_out == $past(mode_out)) else $error("bkpt entry");
  pabt_wins_a:
  assert property (run && bkpt_hit_in && prefetch_abort_in && !wpt_hit_in && dr_q == 3'h0
    && !debug_request_input_in |=> !irq_disable_out) else $error("pabt ignored");
  wpt_plain_a:
  assert property (wp && !data_abort_in && !irq_pending_in && !other_exc_in
    |=> debug_acknowledge_out && pc_adv_out == ADV_WPT) else $error("wpt entry");
  wpt_exc_a:
  assert property (wp && !data_abort_in && (irq_pending_in || other_exc_in) |=>
    pc_adv_out == ADV_WEXC && mode_out == ($past(irq_pending_in) ? MODE_IRQ
    : $past(exc_mode_in))) else $error("wpt exc entry");
  abort_hold_a:
  assert property (wp && data_abort_in |=> !debug_acknowledge_out && irq_disable_out)
    else $error("abort not held");
  vector_entry_a:
  assert property (irq_disable_out && !debug_acknowledge_out && !sys_speed_out
    && vector_fetched_in |-> ##[1:2] (debug_acknowledge_out && mode_out == MODE_ABT))
    else $error("vector entry");
  debug_insn_a:
  assert property (debug_acknowledge_out && insn_exec_in && !flg_q |=>
    pc_adv_out == $past(pc_adv_out) + ADV_INSN) else $error("insn advance");
  sys_insn_a:
  assert property (debug_acknowledge_out && insn_exec_in && flg_q |=> sys_speed_out
    && pc_adv_out == $past(pc_adv_out) + ADV_SYS) else $error("sys advance");
  sys_abort_a:
  assert property (sys_speed_out && sys_abort_in |=> mode_out == MODE_ABT)
    else $error("sys abort mode");
  irq_off_a:
  assert property (debug_acknowledge_out |-> irq_disable_out) else $error("irq on");
  restart_a:
  assert property (resume_fetch_out |-> !debug_acknowledge_out
    && $past(debug_acknowledge_out) ##1 !resume_fetch_out) else $error("restart");
  bus_err_a:
  assert property (psel_in && penable_in && paddr_in[1:0] == 2'h0 |->
    pslverr_out == (paddr_in > REG_CHAIN)) else $error("slave error");
  cover property (run && bkpt_hit_in && !prefetch_abort_in);
  cover property (sys_speed_out && sys_abort_in);
  cover property (resume_fetch_out);
endmodule : dbg_checker
bind debug_pc_tracking_priority dbg_checker u_dbg_checker (.mclk_in, .rst_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pslverr_out, .debug_request_input_in,
  .bkpt_hit_in, .wpt_hit_in, .prefetch_abort_in, .data_abort_in, .irq_pending_in,
  .other_exc_in, .exc_mode_in, .vector_fetched_in, .insn_exec_in, .break_point_flag_in,
  .sys_abort_in, .debug_acknowledge_out, .irq_disable_out, .sys_speed_out,
  .resume_fetch_out, .mode_out, .pc_adv_out);
`default_nettype wire

// [sim/jtag_host.sv]
// Test-port host model walking the controller with an 800 ns clock
`timescale 1ns/10ps
`default_nettype none
module jtag_host
(
  // Scan pins toward the block
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  // Serial data back
  input wire logic tdo_in
);
  // Clock parked low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // One clock; pins move at the fall, tdo read late in the high half
  task automatic step(input logic m, input logic d, output logic o);
    tms_out <= m;
    tdi_out <= d;
    #400 tck_out <= 1'b1;
    #390 o = tdo_in;
    #10 tck_out <= 1'b0;
  endtask : step
  // Five ones reach reset, a zero parks in idle
  task automatic reset_tap();
    logic o;
    for (int i = 0; i < 6; i++) begin
      step(i < 5, ~tdi_out, o);
    end
  endtask : reset_tap
  // Idle to shift, n bits LSB first, then update and back to idle
  task automatic scan(input logic ir, input int n, input logic [104:0] din,
                      output logic [104:0] dout);
    logic o;
    dout = '0;
    if (ir) begin
      step(1'b1, ~tdi_out, o);
    end
    step(1'b1, ~tdi_out, o);
    step(1'b0, ~tdi_out, o);
    step(1'b0, ~tdi_out, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, ~tdi_out, o);
    step(1'b0, ~tdi_out, o);
    tdi_out <= ~tdi_out; // Idle data keeps changing, never a stale bit
  endtask : scan
endmodule : jtag_host
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the debug tracker
`timescale 1ns/10ps
`default_nettype none
module tb
  import dbg_pkg::*;
;
  logic mclk_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic tck_in, tms_in, tdi_in, tdo_out, tdo_oe_out, debug_request_input_in;
  logic debug_acknowledge_out, irq_disable_out, sys_speed_out, resume_fetch_out, er;
  logic [11:0] paddr_in;
  logic [4:0] exc_mode_in, mode_out;
  logic [31:0] pwdata_in, prdata_out, pc_adv_out, core_data_in, core_addr_in, rd;
  logic [CTRL_CELLS-1:0] ctrl_cells_in;
  logic [CHAIN_LEN-1:0] chain_drive_out, sh, exp_c;
  logic [10:0] ev; // Event pulses, bkpt at the top down to sys abort
  int fails, n_checks;
  // 10 MHz system clock
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  debug_pc_tracking_priority u_debug_pc_tracking_priority (.mclk_in, .rst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .tck_in, .tms_in, .tdi_in, .tdo_out, .tdo_oe_out, .debug_request_input_in,
    .bkpt_hit_in(ev[10]), .wpt_hit_in(ev[9]), .prefetch_abort_in(ev[8]),
    .data_abort_in(ev[7]), .irq_pending_in(ev[6]), .other_exc_in(ev[5]), .exc_mode_in,
    .vector_fetched_in(ev[4]), .insn_exec_in(ev[3]), .break_point_flag_in(ev[2]),
    .sys_done_in(ev[1]), .sys_abort_in(ev[0]), .core_data_in, .core_addr_in,
    .ctrl_cells_in, .debug_acknowledge_out, .irq_disable_out, .sys_speed_out,
    .resume_fetch_out, .mode_out, .pc_adv_out, .chain_drive_out);
  jtag_host u_jtag_host (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in),
    .tdo_in(tdo_out));
  // Compare a word, a bit, a chain image
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk
  task automatic ck1(input logic got, input logic want);
    chk({31'h0, got}, {31'h0, want});
  endtask : ck1
  task automatic chkc(input logic [CHAIN_LEN-1:0] got, input logic [CHAIN_LEN-1:0] want);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chkc
  // One APB transfer; read data and error land in rd and er
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Wait states are open-ended; only the watchdog ends a hang
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask : apb
  // Pulse events for one edge, then let that edge's results settle
  task automatic fire(input logic [10:0] e);
    ev <= e;
    @(posedge mclk_in);
    ev <= 11'h000;
    @(posedge mclk_in);
  endtask : fire
  // Bounded wait for the acknowledge level
  task automatic wack(input logic v);
    int k;
    k = 0;
    while (debug_acknowledge_out !== v && k < 400) begin
      @(posedge mclk_in);
      k++;
    end
    ck1(debug_acknowledge_out, v);
  endtask : wack
  // Scan through the host, then realign to the system clock
  task automatic sc(input logic ir, input int n, input logic [CHAIN_LEN-1:0] d);
    u_jtag_host.scan(ir, n, d, sh);
    @(posedge mclk_in);
  endtask : sc
  // Restart, then park on bypass so a later entry is not released at once
  task automatic restart();
    sc(1'b1, IR_W, {101'h0, IR_RESTART});
    wack(1'b0);
    sc(1'b1, IR_W, {101'h0, IR_BYPASS});
  endtask : restart
  task automatic s_regs();
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {31'h0, CTRL_EN_RST});
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd, {11'h0, MODE_USR, 16'h0});
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    ck1(er, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h0);
    fire(11'h400);
    ck1(debug_acknowledge_out, 1'b0);
    apb(1'b1, REG_CTRL, 32'h1);
  endtask : s_regs
  // Breakpoint with irq pending, two debug instructions, one system access
  task automatic s_bkpt();
    fire(11'h440);
    chk(pc_adv_out, ADV_BKPT);
    chk({27'h0, mode_out}, {27'h0, MODE_USR});
    ck1(irq_disable_out, 1'b1);
    fire(11'h008);
    fire(11'h00C);
    fire(11'h008);
    ck1(sys_speed_out, 1'b1);
    fire(11'h002);
    wack(1'b1);
    chk(pc_adv_out, ADV_BKPT + 2 * ADV_INSN + ADV_SYS);
    restart();
    fire(11'h500);
    ck1(debug_acknowledge_out, 1'b0);
  endtask : s_bkpt
  // Watchpoint alone, with irq, with another exception
  task automatic s_wpt();
    logic [10:0] e [3] = '{11'h200, 11'h240, 11'h220};
    logic [31:0] pc [3] = '{ADV_WPT, ADV_WEXC, ADV_WEXC};
    logic [4:0] md [3] = '{MODE_USR, MODE_IRQ, 5'h1B};
    for (int i = 0; i < 3; i++) begin
      fire(e[i]);
      wack(1'b1);
      chk(pc_adv_out, pc[i]);
      if (i > 0) chk({27'h0, mode_out}, {27'h0, md[i]});
      apb(1'b0, REG_STAT, 32'h0);
      ck1(rd[STAT_IRQ_BIT], i == 1);
      apb(1'b1, REG_CTRL, 32'h3);
      restart();
    end
    fire(11'h280);
    ck1(debug_acknowledge_out, 1'b0);
    fire(11'h010);
    wack(1'b1);
    chk({27'h0, mode_out}, {27'h0, MODE_ABT});
    apb(1'b0, REG_STAT, 32'h0);
    ck1(rd[STAT_ABT_BIT], 1'b1);
    apb(1'b1, REG_CTRL, 32'h3);
    restart();
  endtask : s_wpt
  // Debug request, then a system access that aborts
  task automatic s_dreq();
    // Pending interrupt moves the mode off abort before the aborted access
    {debug_request_input_in, ev} <= 12'h840;
    wack(1'b1);
    debug_request_input_in <= 1'b0;
    chk(pc_adv_out, ADV_DREQ);
    fire(11'h00C);
    fire(11'h008);
    fire(11'h001);
    wack(1'b1);
    chk({27'h0, mode_out}, {27'h0, MODE_ABT});
    chk(pc_adv_out, ADV_DREQ + ADV_INSN + ADV_SYS);
    restart();
  endtask : s_dreq
  // Capture, shift out and update the boundary chain under EXTEST
  task automatic s_chain();
    // Cell 33 shows the idle breakpoint input, not the control cell input
    exp_c = {32'h0, 41'h0AB_CDEF_0122, 32'hA5C3_0F96};
    for (int k = 0; k < 32; k++) exp_c[IDX_ADDR31 + k] = core_addr_in[31 - k];
    sc(1'b1, IR_W, {101'h0, IR_EXTEST});
    chk({28'h0, sh[3:0]}, {28'h0, IR_CAPTURE});
    apb(1'b0, REG_CHAIN, 32'h0);
    chk(rd, {28'h0, IR_EXTEST});
    sc(1'b0, CHAIN_LEN, ~exp_c);
    chkc(sh, exp_c);
    chkc(chain_drive_out, ~exp_c);
    ck1(tdo_oe_out, 1'b0);
    sc(1'b1, IR_W, {101'h0, IR_BYPASS});
  endtask : s_chain
  task automatic summarize();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    {rst_in, psel_in, penable_in, pwrite_in, debug_request_input_in} = 5'h10;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    ev = 11'h000;
    exc_mode_in = 5'h1B;
    core_data_in = 32'hA5C3_0F96;
    core_addr_in = 32'h1234_5678;
    ctrl_cells_in = 41'h0AB_CDEF_0123;
    fails = 0;
    n_checks = 0;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    u_jtag_host.reset_tap();
    @(posedge mclk_in);
    s_regs();
    s_bkpt();
    s_wpt();
    s_dreq();
    s_chain();
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    #3_000_000;
    fails++;
    summarize();
  end
endmodule : tb
`default_nettype wire
